// >>> src/card_socket_cycle_timer.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module card_socket_cycle_timer
  import card_timer_pkg::*;
#(
  parameter int unsigned PRES_0 = 1,
  parameter int unsigned PRES_1 = 16,
  parameter int unsigned PRES_2 = 64,
  parameter int unsigned PRES_3 = 256
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [APB_AW-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  output var  logic [CARD_AW-1:0] card_addr,
  output var  logic               card_reg_n,
  output var  logic               card_ce1_n,
  output var  logic               card_ce2_n,
  output var  logic               card_oe_n,
  output var  logic               card_we_n,
  output var  logic               card_iord_n,
  output var  logic               card_iowr_n,
  output var  logic [CARD_DW-1:0] card_data_out,
  output var  logic               card_data_oe,
  input  wire logic [CARD_DW-1:0] card_data_in,
  input  wire logic               card_wait_n,
  input  wire logic               card_iois16_n
);

  // ==========================================================
  // timer value decode
  function automatic logic [CNT_W-1:0] phase_len(input logic [7:0] t);
    logic [CNT_W-1:0] pres;
    case (t[PRES_LSB +: PRES_W])
      2'h0:    pres = CNT_W'(PRES_0);
      2'h1:    pres = CNT_W'(PRES_1);
      2'h2:    pres = CNT_W'(PRES_2);
      default: pres = CNT_W'(PRES_3);
    endcase
    phase_len = CNT_W'(pres * CNT_W'(t[VAL_LSB +: VAL_W])) + CNT_W'(1);
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [CARD_DW+1:0] pins_s;
  logic               wait_act;
  logic               iois_act;
  logic [CARD_DW-1:0] data_s;

  pin_sync #(.W(CARD_DW + 2)) u_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .d       ({card_wait_n, card_iois16_n, card_data_in}),
    .q       (pins_s)
  );

  assign wait_act = !pins_s[CARD_DW+1];
  assign iois_act = !pins_s[CARD_DW];
  assign data_s   = pins_s[CARD_DW-1:0];

  // ==========================================================
  // register file state
  logic [7:0]         tim_r [0:NUM_TIM-1];
  logic [7:0]         tim_nxt [0:NUM_TIM-1];
  logic [CARD_AW-1:0] addr_reg_r, addr_reg_nxt;
  logic [CARD_DW-1:0] wdata_reg_r, wdata_reg_nxt;
  logic               bypass_r, bypass_nxt;
  logic               done_r, done_nxt;
  logic               tim_touched_r, tim_touched_nxt;
  logic [31:0]        prdata_nxt;
  logic               pready_nxt;
  logic               pslverr_nxt;

  // cycle state
  cyc_state_t         state_r, state_nxt;
  logic [CTRL_W-1:0]  ctl_r, ctl_nxt;
  logic [CNT_W-1:0]   c_len_r, c_len_nxt;
  logic [CNT_W-1:0]   r_len_r, r_len_nxt;
  logic               wide_r, wide_nxt;
  logic               waited_r, waited_nxt;
  logic               cap_done_r, cap_done_nxt;
  logic [CARD_DW-1:0] rdata_r, rdata_nxt;
  logic [3:0]         elapsed_r, elapsed_nxt;
  logic [CARD_AW-1:0] addr_nxt;
  logic               reg_n_nxt, ce1_n_nxt, ce2_n_nxt;
  logic               oe_n_nxt, we_n_nxt, iord_n_nxt, iowr_n_nxt;
  logic [CARD_DW-1:0] dout_nxt;
  logic               doe_nxt;
  logic               cyc_done;

  // counter
  logic               cnt_load;
  logic [CNT_W-1:0]   cnt_val;
  logic [CNT_W-1:0]   cnt_r;
  logic               cnt_last;

  phase_counter #(.W(CNT_W)) u_cnt (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .cnt      (cnt_r),
    .last     (cnt_last)
  );

  // ==========================================================
  // APB decode
  logic [7:0]  idx;
  logic        hit;
  logic        access;
  logic        wr_en;
  logic        start;
  logic [31:0] rd_val;
  logic [2:0]  set_base;
  logic        strobe_on;

  assign idx       = paddr[9:2];
  assign hit       = (paddr[APB_AW-1:10] == '0) && (idx >= IDX_SETUP0) && (idx <= IDX_CLOCK);
  assign access    = psel && penable && !pready;
  assign wr_en     = psel && penable && pready && pwrite && hit;
  assign start     = wr_en && (idx == IDX_CTRL) && (state_r == ST_IDLE);
  assign set_base  = pwdata[CTRL_SET] ? 3'h3 : 3'h0;
  assign strobe_on = !(card_oe_n && card_we_n && card_iord_n && card_iowr_n);

  always_comb begin
    rd_val = '0;
    case (idx)
      IDX_ADDR:   rd_val[CARD_AW-1:0] = addr_reg_r;
      IDX_WDATA:  rd_val[CARD_DW-1:0] = wdata_reg_r;
      IDX_CTRL:   rd_val[CTRL_W-1:0]  = ctl_r;
      IDX_STATUS: begin
        rd_val[STAT_BUSY] = (state_r != ST_IDLE);
        rd_val[STAT_DONE] = done_r;
        rd_val[STAT_WIDE] = wide_r;
        rd_val[STAT_WAIT] = waited_r;
      end
      IDX_RDATA:  rd_val[CARD_DW-1:0] = rdata_r;
      IDX_CLOCK:  rd_val[CLK_BYPASS]  = bypass_r;
      default: begin
        if (hit) begin
          rd_val[7:0] = tim_r[3'(idx - IDX_SETUP0)];
        end
      end
    endcase
  end

  // ==========================================================
  // register file: one wait state, then pready with the data
  always_comb begin
    pready_nxt      = access;
    prdata_nxt      = prdata;
    pslverr_nxt     = 1'b0;
    tim_nxt         = tim_r;
    addr_reg_nxt    = addr_reg_r;
    wdata_reg_nxt   = wdata_reg_r;
    bypass_nxt      = bypass_r;
    done_nxt        = done_r;
    tim_touched_nxt = tim_touched_r;
    if (access) begin
      prdata_nxt  = pwrite ? '0 : rd_val;
      pslverr_nxt = !hit;
    end
    if (wr_en) begin
      case (idx)
        IDX_ADDR:   addr_reg_nxt  = pwdata[CARD_AW-1:0];
        IDX_WDATA:  wdata_reg_nxt = pwdata[CARD_DW-1:0];
        IDX_CLOCK:  bypass_nxt    = pwdata[CLK_BYPASS];
        IDX_STATUS: begin
          if (pwdata[STAT_DONE]) begin
            done_nxt = 1'b0;
          end
        end
        IDX_CTRL:   ;
        default: begin
          // timing writes during a cycle only affect the next cycle
          tim_nxt[3'(idx - IDX_SETUP0)] = pwdata[7:0];
          tim_touched_nxt = tim_touched_r || (idx <= IDX_RECOV0);
        end
      endcase
    end
    // completion beats a clear in the same cycle
    if (cyc_done) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready        <= 1'b0;
      prdata        <= '0;
      pslverr       <= 1'b0;
      tim_r[0]      <= SETUP_RST;
      tim_r[1]      <= CMD_RST;
      tim_r[2]      <= RECOV_RST;
      tim_r[3]      <= SETUP_RST;
      tim_r[4]      <= CMD_RST;
      tim_r[5]      <= RECOV_RST;
      addr_reg_r    <= '0;
      wdata_reg_r   <= '0;
      bypass_r      <= 1'b0;
      done_r        <= 1'b0;
      tim_touched_r <= 1'b0;
    end else begin
      pready        <= pready_nxt;
      prdata        <= prdata_nxt;
      pslverr       <= pslverr_nxt;
      tim_r         <= tim_nxt;
      addr_reg_r    <= addr_reg_nxt;
      wdata_reg_r   <= wdata_reg_nxt;
      bypass_r      <= bypass_nxt;
      done_r        <= done_nxt;
      tim_touched_r <= tim_touched_nxt;
    end
  end

  // ==========================================================
  // socket cycle sequencer
  always_comb begin
    state_nxt    = state_r;
    ctl_nxt      = ctl_r;
    c_len_nxt    = c_len_r;
    r_len_nxt    = r_len_r;
    wide_nxt     = wide_r;
    waited_nxt   = waited_r;
    cap_done_nxt = cap_done_r;
    rdata_nxt    = rdata_r;
    elapsed_nxt  = elapsed_r;
    addr_nxt     = card_addr;
    reg_n_nxt    = card_reg_n;
    ce1_n_nxt    = card_ce1_n;
    ce2_n_nxt    = card_ce2_n;
    oe_n_nxt     = card_oe_n;
    we_n_nxt     = card_we_n;
    iord_n_nxt   = card_iord_n;
    iowr_n_nxt   = card_iowr_n;
    dout_nxt     = card_data_out;
    doe_nxt      = card_data_oe;
    cnt_load     = 1'b0;
    cnt_val      = '0;
    cyc_done     = 1'b0;
    if (state_r != ST_IDLE && elapsed_r < IOIS_SEEN_TCP) begin
      elapsed_nxt = elapsed_r + 4'h1;
    end
    // width flag only in the window after start and not near command end
    if ((state_r == ST_SETUP || state_r == ST_CMD) && ctl_r[CTRL_IO] && ctl_r[CTRL_WORD]) begin
      if (!wide_r && iois_act && elapsed_r < IOIS_SEEN_TCP &&
          !(state_r == ST_CMD && cnt_r <= IOIS_LEAD_TCP)) begin
        wide_nxt = 1'b1;
      end
      if (wide_r) begin
        ce2_n_nxt = 1'b0;
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          ctl_nxt      = pwdata[CTRL_W-1:0];
          state_nxt    = ST_SETUP;
          cnt_load     = 1'b1;
          cnt_val      = phase_len(tim_r[set_base]);
          c_len_nxt    = phase_len(tim_r[set_base + 3'h1]);
          r_len_nxt    = phase_len(tim_r[set_base + 3'h2]);
          wide_nxt     = 1'b0;
          waited_nxt   = 1'b0;
          cap_done_nxt = 1'b0;
          elapsed_nxt  = '0;
          addr_nxt     = addr_reg_r;
          reg_n_nxt    = !pwdata[CTRL_ATTR];
          ce1_n_nxt    = 1'b0;
          ce2_n_nxt    = !(pwdata[CTRL_WORD] && !pwdata[CTRL_IO]);
          dout_nxt     = wdata_reg_r;
          doe_nxt      = pwdata[CTRL_WRITE];
        end
      end
      ST_SETUP: begin
        if (cnt_last) begin
          state_nxt  = ST_CMD;
          cnt_load   = 1'b1;
          cnt_val    = c_len_r;
          oe_n_nxt   = ctl_r[CTRL_IO] || ctl_r[CTRL_WRITE];
          we_n_nxt   = ctl_r[CTRL_IO] || !ctl_r[CTRL_WRITE];
          iord_n_nxt = !ctl_r[CTRL_IO] || ctl_r[CTRL_WRITE];
          iowr_n_nxt = !ctl_r[CTRL_IO] || !ctl_r[CTRL_WRITE];
        end
      end
      ST_CMD: begin
        // wait seen through two flops; the hold also leaves a clock for data
        if (wait_act && cnt_r <= WAIT_HOLD) begin
          cnt_load   = 1'b1;
          cnt_val    = WAIT_HOLD;
          waited_nxt = 1'b1;
        end else if (cnt_last) begin
          state_nxt  = ST_RECOV;
          cnt_load   = 1'b1;
          cnt_val    = r_len_r;
          oe_n_nxt   = 1'b1;
          we_n_nxt   = 1'b1;
          iord_n_nxt = 1'b1;
          iowr_n_nxt = 1'b1;
        end
        // a command of fewer than two clocks cannot meet the capture lead
        if (!ctl_r[CTRL_WRITE] && !cap_done_r && !wait_act && cnt_r <= CAP_LEAD_TCP) begin
          rdata_nxt    = data_s;
          cap_done_nxt = 1'b1;
        end
      end
      ST_RECOV: begin
        if (cnt_last) begin
          state_nxt = ST_IDLE;
          reg_n_nxt = 1'b1;
          ce1_n_nxt = 1'b1;
          ce2_n_nxt = 1'b1;
          doe_nxt   = 1'b0;
          cyc_done  = 1'b1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ST_IDLE;
      ctl_r         <= '0;
      c_len_r       <= '0;
      r_len_r       <= '0;
      wide_r        <= 1'b0;
      waited_r      <= 1'b0;
      cap_done_r    <= 1'b0;
      rdata_r       <= '0;
      elapsed_r     <= '0;
      card_addr     <= '0;
      card_reg_n    <= 1'b1;
      card_ce1_n    <= 1'b1;
      card_ce2_n    <= 1'b1;
      card_oe_n     <= 1'b1;
      card_we_n     <= 1'b1;
      card_iord_n   <= 1'b1;
      card_iowr_n   <= 1'b1;
      card_data_out <= '0;
      card_data_oe  <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      ctl_r         <= ctl_nxt;
      c_len_r       <= c_len_nxt;
      r_len_r       <= r_len_nxt;
      wide_r        <= wide_nxt;
      waited_r      <= waited_nxt;
      cap_done_r    <= cap_done_nxt;
      rdata_r       <= rdata_nxt;
      elapsed_r     <= elapsed_nxt;
      card_addr     <= addr_nxt;
      card_reg_n    <= reg_n_nxt;
      card_ce1_n    <= ce1_n_nxt;
      card_ce2_n    <= ce2_n_nxt;
      card_oe_n     <= oe_n_nxt;
      card_we_n     <= we_n_nxt;
      card_iord_n   <= iord_n_nxt;
      card_iowr_n   <= iowr_n_nxt;
      card_data_out <= dout_nxt;
      card_data_oe  <= doe_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_setup_to_strobe: assert property (
    (state_r == ST_SETUP && cnt_r == 16'h0001) |=> (state_r == ST_CMD && strobe_on && !card_ce1_n))
    else $error("strobe did not start after setup count");
  chk_strobe_release: assert property (
    $fell(strobe_on) |-> ($past(cnt_r) == 16'h0001 && !$past(wait_act) && state_r == ST_RECOV))
    else $error("strobe released before command count ran out");
  chk_recov_hold: assert property (
    (state_r == ST_RECOV) |-> ($stable(card_addr) && $stable(card_data_out) && !card_ce1_n))
    else $error("address or data moved during recovery");
  chk_timer_defaults: assert property (
    !tim_touched_r |-> (tim_r[0] == SETUP_RST && tim_r[1] == CMD_RST && tim_r[2] == RECOV_RST))
    else $error("timer set 0 lost its reset value");
  chk_wait_extend: assert property (
    (state_r == ST_CMD && wait_act) |=> strobe_on [*2])
    else $error("strobe released too soon after wait");
  // capture loads from the second sync stage, so its pin sample is two edges older
  chk_mem_capture: assert property (
    ($rose(card_oe_n) && state_r == ST_RECOV) |-> $past(cap_done_r))
    else $error("memory read data not captured two clocks early");
  chk_io_capture: assert property (
    ($rose(card_iord_n) && state_r == ST_RECOV) |-> $past(cap_done_r))
    else $error("io read data not captured two clocks early");
  chk_width_window: assert property (
    $rose(wide_r) |-> ($past(elapsed_r) < IOIS_SEEN_TCP))
    else $error("width flag taken outside the start window");
  chk_wide_enable: assert property (
    ($fell(card_ce2_n) && ctl_r[CTRL_IO]) |-> ($past(wide_r) && $past(state_r) != ST_IDLE))
    else $error("high byte enabled without width flag");
  chk_late_width: assert property (
    (state_r == ST_CMD && cnt_r <= IOIS_LEAD_TCP && !wide_r) |=> !wide_r)
    else $error("width flag accepted too close to command end");
  chk_cycle_load: assert property (
    start |=> (state_r == ST_SETUP && cnt_r == phase_len($past(tim_r[set_base]))))
    else $error("setup count not loaded from selected set");

  cov_write_cycle: cover property (cyc_done && ctl_r[CTRL_WRITE]);
  cov_read_cycle: cover property (cyc_done && !ctl_r[CTRL_WRITE] && cap_done_r);
  cov_wait_ext: cover property (state_r == ST_CMD && waited_r && cnt_last);
  cov_wide_io: cover property (cyc_done && wide_r);

endmodule
`default_nettype wire

// >>> src/card_timer_pkg.sv
// Notes on behaviour
// - setup phase of S = prescale*multiplier+1 clocks before the command strobe
// - command strobe held C = prescale*multiplier+1 clocks from command timing
// - address and write data stay stable R clocks after strobe release
// - timer set 0 resets to setup 01, command 06, recovery 03
// - strobe extended while wait active, released two or more clocks after
// - memory read data captured two or more clocks before output enable ends
// - i/o read data captured two or more clocks before i/o read ends
// - i/o high-byte enable follows the width flag by at least one clock; memory word cycles enable it at start
// - width flag not accepted within three clocks of command end
// - internal clock equals the block clock; bypass state kept for software
package card_timer_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SETUP0  = 8'h3A;
  localparam logic [7:0] IDX_CMD0    = 8'h3B;
  localparam logic [7:0] IDX_RECOV0  = 8'h3C;
  localparam logic [7:0] IDX_SETUP1  = 8'h3D;
  localparam logic [7:0] IDX_CMD1    = 8'h3E;
  localparam logic [7:0] IDX_RECOV1  = 8'h3F;
  localparam logic [7:0] IDX_ADDR    = 8'h40;
  localparam logic [7:0] IDX_WDATA   = 8'h41;
  localparam logic [7:0] IDX_CTRL    = 8'h42;
  localparam logic [7:0] IDX_STATUS  = 8'h43;
  localparam logic [7:0] IDX_RDATA   = 8'h44;
  localparam logic [7:0] IDX_CLOCK   = 8'h45;
  localparam int unsigned APB_AW     = 12;
  localparam int unsigned NUM_TIM    = 6;

  // ==========================================================
  // reset values and field layout
  localparam logic [7:0] SETUP_RST   = 8'h01;
  localparam logic [7:0] CMD_RST     = 8'h06;
  localparam logic [7:0] RECOV_RST   = 8'h03;
  localparam int unsigned VAL_LSB    = 0;
  localparam int unsigned VAL_W      = 6;
  localparam int unsigned PRES_LSB   = 6;
  localparam int unsigned PRES_W     = 2;
  localparam int unsigned CTRL_WRITE = 0;
  localparam int unsigned CTRL_IO    = 1;
  localparam int unsigned CTRL_WORD  = 2;
  localparam int unsigned CTRL_ATTR  = 3;
  localparam int unsigned CTRL_SET   = 4;
  localparam int unsigned CTRL_W     = 5;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_DONE  = 1;
  localparam int unsigned STAT_WIDE  = 2;
  localparam int unsigned STAT_WAIT  = 3;
  localparam int unsigned CLK_BYPASS = 0;
  localparam int unsigned CARD_AW    = 26;
  localparam int unsigned CARD_DW    = 16;
  localparam int unsigned CNT_W      = 16;

  // ==========================================================
  // timing, in internal clock periods (one pclk each)
  localparam int unsigned PCLK_MHZ        = 40;
  localparam int unsigned TCP_NS          = 1000 / PCLK_MHZ;
  localparam logic [CNT_W-1:0] WAIT_TAIL_TCP   = 16'h0002;
  localparam logic [CNT_W-1:0] DATA_VALID_TCP  = 16'h0001;
  localparam logic [CNT_W-1:0] WAIT_HOLD       = WAIT_TAIL_TCP + DATA_VALID_TCP;
  localparam logic [CNT_W-1:0] CAP_LEAD_TCP    = 16'h0002;
  localparam logic [CNT_W-1:0] IOIS_LEAD_TCP   = 16'h0003;
  localparam logic [3:0]       IOIS_WINDOW_TCP = 4'h3;
  // pin flag reaches logic two flops late; one more clock covers a flag just past edge three
  localparam logic [3:0]       SYNC_LAT_TCP    = 4'h2;
  localparam logic [3:0]       IOIS_SEEN_TCP   = IOIS_WINDOW_TCP + SYNC_LAT_TCP + 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_CMD   = 2'b10,
    ST_RECOV = 2'b11
  } cyc_state_t;

endpackage

// >>> src/phase_counter.sv
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output var  logic [W-1:0] cnt,
  output var  logic         last
);
  logic [W-1:0] cnt_nxt;

  // counts remaining clocks of a phase, including the current one
  always_comb begin
    cnt_nxt = cnt;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt != '0) begin
      cnt_nxt = cnt - W'(1);
    end
    last = (cnt == W'(1));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/card_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_model
  import card_timer_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               card_ce1_n,
  input  wire logic               strobe,
  input  wire logic [CARD_DW-1:0] rd_data,
  input  wire logic [7:0]         wait_len,
  input  wire logic               wide,
  output var  logic [CARD_DW-1:0] card_data_in,
  output var  logic               card_wait_n,
  output var  logic               card_iois16_n
);
  logic [7:0] wcnt;
  // ==========
  // card side of the socket
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 8'h00;
      card_wait_n <= 1'b1;
      card_iois16_n <= 1'b1;
      card_data_in <= '0;
    end else begin
      wcnt <= strobe ? wcnt + 8'h01 : 8'h00;
      card_wait_n <= !(strobe && wcnt < wait_len);
      // data toggles while invalid so a stale value cannot pass as a capture
      card_data_in <= (strobe && wcnt >= wait_len) ? rd_data : ~card_data_in;
      card_iois16_n <= !(wide && !card_ce1_n);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import card_timer_pkg::*;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0]  paddr = '0;
  logic [31:0]        pwdata = '0, prdata, rd;
  logic               pready, pslverr, er, wide = 0, w2;
  logic               ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, wait_n, iois_n;
  localparam int unsigned PRES_0 = 1;
  localparam int unsigned PRES_1 = 16;
  logic [CARD_DW-1:0] din, dat = '0, cdout, wd, cd;
  logic [CARD_AW-1:0] caddr, adr, ca;
  logic               creg_n, cdoe, cr, co;
  logic [31:0]        st;
  logic [7:0]         wl = 8'h00, mv [3];
  int                 seed = 4, fail_count = 0, n_checks = 0, su, cm, rc, sc, k;
  wire logic          strb = !(oe_n & we_n & iord_n & iowr_n);

  always #12.5 pclk = ~pclk;

  card_socket_cycle_timer #(.PRES_0(PRES_0), .PRES_1(PRES_1)) card_socket_cycle_timer_i (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_addr(caddr),
    .card_reg_n(creg_n),
    .card_ce1_n(ce1_n), .card_ce2_n(ce2_n), .card_oe_n(oe_n), .card_we_n(we_n),
    .card_iord_n(iord_n), .card_iowr_n(iowr_n), .card_data_out(cdout), .card_data_oe(cdoe),
    .card_data_in(din), .card_wait_n(wait_n), .card_iois16_n(iois_n));

  card_model card_model_i (.pclk(pclk), .presetn(presetn), .card_ce1_n(ce1_n),
    .strobe(strb), .rd_data(dat), .wait_len(wl), .wide(wide), .card_data_in(din),
    .card_wait_n(wait_n), .card_iois16_n(iois_n));

  // ==========
  // phase monitor: counts setup, command and recovery cycles of one socket cycle
  always @(posedge pclk) begin
    if (!ce1_n) begin
      if (strb) begin
        cm <= cm + 1;
        sc <= 1;
        cr <= creg_n;
        co <= cdoe;
      end else if (sc != 0) begin
        rc <= rc + 1;
        ca <= caddr;
        cd <= cdout;
      end else su <= su + 1;
      if (!ce2_n) w2 <= 1'b1;
    end
  end

  // ==========
  // bus and cycle tasks
  function automatic logic [APB_AW-1:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic int tlen(input logic [7:0] v);
    return ((v[7:6] == 2'h1) ? PRES_1 : PRES_0) * v[5:0] + 1;
  endfunction

  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [4:0] ctl, input int es, ec, erc, input logic e2);
    int i;
    su = 0; cm = 0; rc = 0; sc = 0; w2 = 1'b0;
    apb(1'b1, ba(IDX_CTRL), {27'h0, ctl});
    for (i = 0; i < 200; i++) begin
      apb(1'b0, ba(IDX_STATUS), 32'h0);
      if (rd[STAT_DONE] === 1'b1) break;
    end
    st = rd;
    `CHK("setup", es, su)
    if (ec > 0) `CHK("command", ec, cm)
    `CHK("recovery", erc, rc)
    `CHK("address", adr, ca)
    `CHK("reg_select", !ctl[CTRL_ATTR], cr)
    `CHK("data_drive", ctl[CTRL_WRITE], co)
    if (ctl[CTRL_WRITE]) `CHK("wdata", wd, cd)
    `CHK("high_byte", e2, w2)
    apb(1'b1, ba(IDX_STATUS), 32'h2);
  endtask

  task automatic rdchk();
    apb(1'b0, ba(IDX_RDATA), 32'h0);
    `CHK("rdata", {16'h0, dat}, rd)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end

  // ==========
  // scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    mv = '{SETUP_RST, CMD_RST, RECOV_RST};
    for (k = 0; k < 3; k++) begin
      apb(1'b0, ba(IDX_SETUP0 + 8'(k)), 32'h0);
      `CHK("set0_reset", {24'h0, mv[k]}, rd)
    end
    apb(1'b0, 12'h200, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    adr = 26'($random(seed));
    wd = 16'($random(seed));
    apb(1'b1, ba(IDX_ADDR), {6'h00, adr});
    apb(1'b1, ba(IDX_WDATA), {16'h0000, wd});
    apb(1'b1, ba(IDX_CLOCK), 32'h00000001);
    apb(1'b0, ba(IDX_CLOCK), 32'h00000000);
    `CHK("bypass", 32'h00000001, rd)
    dat = 16'($random(seed));
    run(5'h08, 2, 7, 4, 1'b0);
    rdchk();
    for (k = 0; k < 3; k++) begin
      mv[k] = 8'(($random(seed) & 32'h47) + 2);
      apb(1'b1, ba(IDX_SETUP1 + 8'(k)), {24'h0, mv[k]});
      apb(1'b0, ba(IDX_SETUP1 + 8'(k)), 32'h0);
      `CHK("set1_rw", {24'h0, mv[k]}, rd)
    end
    run(5'h15, tlen(mv[0]), tlen(mv[1]), tlen(mv[2]), 1'b1);
    wide = 1'b1;
    dat = 16'($random(seed));
    run(5'h06, 2, 7, 4, 1'b1);
    apb(1'b0, ba(IDX_RDATA), 32'h0);
    `CHK("io_rdata", {16'h0, dat}, rd)
    `CHK("wide_seen", 1'b1, st[STAT_WIDE])
    wide = 1'b0;
    run(5'h06, 2, 7, 4, 1'b0);
    `CHK("wide_seen", 1'b0, st[STAT_WIDE])
    wl = 8'h0A;
    dat = 16'($random(seed));
    run(5'h00, 2, -1, 4, 1'b0);
    `CHK("wait_ext", 1'b1, cm >= 13)
    `CHK("waited", 1'b1, st[STAT_WAIT])
    apb(1'b0, ba(IDX_RDATA), 32'h0);
    `CHK("wait_rdata", {16'h0, dat}, rd)
    report_and_stop();
  end
endmodule
`default_nettype wire
